// file: link_pkg.sv
// Shared constants and state codes for both ends of the radio data/control link.
// Assumes the system clock MCLK runs at 50 MHz at both ends.
package link_pkg;

   localparam int DATA_W        = 8;
   localparam int SYNC_W        = 12;
   localparam int SYS_CLK_MHZ   = 50;
   // Nominal interface clock; a 50 MHz source cannot reach it, see PCLK_HALF_CYC
   localparam int PCLK_NOM_MHZ  = 66;
   // Half period in MCLK cycles: the fastest rate an even divider of MCLK allows
   // while the two-stage input synchronisers still see each interface cycle once
   localparam int PCLK_HALF_CYC = (SYS_CLK_MHZ + 2 * PCLK_NOM_MHZ - 1) / (2 * PCLK_NOM_MHZ) + 1;
   // Interface clock cycles from end of reception to the activity flag falling
   localparam int TAIL_CYC      = 4;

   localparam logic [DATA_W-1:0] BUS_IDLE = 8'h00;
   localparam logic              FLAG_RST = 1'h0;

   typedef enum logic [2:0] {
      ST_RESET    = 3'h0,
      ST_SLEEP    = 3'h1,
      ST_STANDBY  = 3'h2,
      ST_READY    = 3'h3,
      ST_TRANSMIT = 3'h4,
      ST_RECEIVE  = 3'h5
   } phy_state_e;

endpackage

// file: link_if.sv
// Link between the radio front end (phy end) and the medium access controller (mac end).
// Assumes both ends are instantiated by the bench and joined through this interface.
interface link_if;

   logic                          interface_reset_n;
   logic                          transmit_request;
   logic                          receive_request;
   logic                          pclk_stop_request;
   logic                          air_activity_flag;
   logic                          channel_clear_result;
   logic                          phy_interface_clock;
   logic                          mac_interface_clock;
   logic                          phy_data_strobe;
   logic                          mac_data_qualifier;
   logic [link_pkg::DATA_W-1:0]   phy_data_out;
   logic                          phy_data_oe;
   logic [link_pkg::DATA_W-1:0]   mac_data_out;
   logic                          mac_data_oe;
   logic [link_pkg::DATA_W-1:0]   data_bus;

   // Resolved bus level; an undriven bus reads as the idle value
   assign data_bus = phy_data_oe ? phy_data_out :
                     (mac_data_oe ? mac_data_out : link_pkg::BUS_IDLE);

   modport phy (
      input  interface_reset_n,
      input  transmit_request,
      input  receive_request,
      input  pclk_stop_request,
      input  mac_interface_clock,
      input  mac_data_qualifier,
      input  data_bus,
      output air_activity_flag,
      output channel_clear_result,
      output phy_interface_clock,
      output phy_data_strobe,
      output phy_data_out,
      output phy_data_oe
   );

   modport mac (
      output interface_reset_n,
      output transmit_request,
      output receive_request,
      output pclk_stop_request,
      output mac_interface_clock,
      output mac_data_qualifier,
      output mac_data_out,
      output mac_data_oe,
      input  air_activity_flag,
      input  channel_clear_result,
      input  phy_interface_clock,
      input  phy_data_strobe,
      input  data_bus
   );

endinterface

// file: phy_link_end.sv
// Radio front end side of the link: state, interface clock, activity flag, byte handshake.
// Assumes MCLK at 50 MHz; link inputs arrive asynchronous, and all but the reset and the returned clock pass two flip-flops.
module phy_link_end #(
   parameter int HALF = link_pkg::PCLK_HALF_CYC,
   parameter int TAIL = link_pkg::TAIL_CYC
) (
   input  wire logic                        MCLK,
   input  wire logic                        RESETN,
   link_if.phy                              LINK,
   input  wire logic                        SLEEP_REQ,
   input  wire logic                        READY_REQ,
   input  wire logic                        TX_AIR_START,
   input  wire logic                        TX_AIR_DONE,
   input  wire logic                        TX_NEED,
   input  wire logic                        RX_PREAMBLE,
   input  wire logic [link_pkg::DATA_W-1:0] RX_BYTE,
   input  wire logic                        RX_BYTE_VALID,
   input  wire logic                        RX_AIR_DONE,
   input  wire logic                        CCA_CLEAR,
   input  wire logic                        MGMT_PHY_DRIVES,
   input  wire logic [link_pkg::DATA_W-1:0] MGMT_DATA,
   output logic [link_pkg::DATA_W-1:0]      TX_BYTE,
   output logic                             TX_BYTE_VALID,
   output logic                             LINK_TICK,
   output logic [2:0]                       POWER_STATE
);

   localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
   localparam int TW = $clog2(TAIL + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(HALF - 1);
   localparam logic [CW-1:0] CNT_PRE  = CW'(HALF - 2);
   localparam logic [TW-1:0] TAIL_LD  = TW'(TAIL);
   localparam logic [TW-1:0] TAIL_ONE = TW'(1);

   generate
      if (HALF < 2) begin : g_half_chk
         $error("HALF must be at least 2");
      end
      if (TAIL < 1) begin : g_tail_chk
         $error("TAIL must be at least 1");
      end
   endgenerate

   link_pkg::phy_state_e                state_reg;
   logic                                arst_n;
   logic [link_pkg::SYNC_W-1:0]         s1_reg;
   logic [link_pkg::SYNC_W-1:0]         s2_reg;
   logic                                stop_s;
   logic                                tx_s;
   logic                                rx_s;
   logic                                qual_s;
   logic [link_pkg::DATA_W-1:0]         dat_s;
   logic [CW-1:0]                       cnt_reg;
   logic                                pclk_reg;
   logic                                run;
   logic                                rise;
   logic                                tick_reg;
   logic                                wake_reg;
   logic                                flag_reg;
   logic [TW-1:0]                       tail_reg;
   logic                                strobe_reg;
   logic [link_pkg::DATA_W-1:0]         dout_reg;
   logic                                doe_reg;
   logic                                cca_reg;
   logic [link_pkg::DATA_W-1:0]         txb_reg;
   logic                                txv_reg;
   logic                                in_tx;
   logic                                in_rx;

   // Link reset is asynchronous; either source clears the whole end
   assign arst_n = RESETN & LINK.interface_reset_n;

   // Two-stage synchronisers for the stop, mode, qualifier and bus link inputs
   always_ff @(posedge MCLK or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= {LINK.pclk_stop_request, LINK.transmit_request,
                    LINK.receive_request, LINK.mac_data_qualifier, LINK.data_bus};
         s2_reg <= s1_reg;
      end
   end

   assign stop_s = s2_reg[11];
   assign tx_s   = s2_reg[10];
   assign rx_s   = s2_reg[9];
   assign qual_s = s2_reg[8];
   assign dat_s  = s2_reg[7:0];
   assign in_tx  = (state_reg == link_pkg::ST_TRANSMIT);
   assign in_rx  = (state_reg == link_pkg::ST_RECEIVE);

   // Clock runs except in sleep, and in standby while stop is requested
   assign run  = (state_reg != link_pkg::ST_SLEEP) &&
                 !((state_reg == link_pkg::ST_STANDBY) && stop_s);
   assign rise = (cnt_reg == CNT_LAST) && !pclk_reg && run;

   // Divider; a started high phase always completes so no runt pulse escapes
   always_ff @(posedge MCLK or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg  <= '0;
         pclk_reg <= 1'h0;
      end else if (!run && !pclk_reg) begin
         cnt_reg  <= '0;
      end else if (cnt_reg == CNT_LAST) begin
         cnt_reg  <= '0;
         pclk_reg <= ~pclk_reg;
      end else begin
         cnt_reg  <= cnt_reg + CW'(1);
      end
   end

   // Marks the MCLK cycle whose closing edge is the interface clock rise
   always_ff @(posedge MCLK or negedge arst_n) begin
      if (!arst_n) begin
         tick_reg <= 1'h0;
      end else begin
         tick_reg <= (cnt_reg == CNT_PRE) && !pclk_reg && run;
      end
   end

   // Sleep exit is evaluated every cycle: the interface clock is off then
   always_ff @(posedge MCLK or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= link_pkg::ST_RESET;
      end else if (state_reg == link_pkg::ST_SLEEP) begin
         if (tx_s && rx_s) begin
            state_reg <= link_pkg::ST_STANDBY;
         end
      end else if (rise) begin
         unique case (state_reg)
            link_pkg::ST_RESET: begin
               state_reg <= link_pkg::ST_STANDBY;
            end
            link_pkg::ST_STANDBY: begin
               if (SLEEP_REQ) begin
                  state_reg <= link_pkg::ST_SLEEP;
               end else if (tx_s && !rx_s) begin
                  state_reg <= link_pkg::ST_TRANSMIT;
               end else if (rx_s && !tx_s) begin
                  state_reg <= link_pkg::ST_RECEIVE;
               end else if (READY_REQ) begin
                  state_reg <= link_pkg::ST_READY;
               end
            end
            link_pkg::ST_READY: begin
               if (tx_s && !rx_s) begin
                  state_reg <= link_pkg::ST_TRANSMIT;
               end else if (rx_s && !tx_s) begin
                  state_reg <= link_pkg::ST_RECEIVE;
               end else if (!READY_REQ) begin
                  state_reg <= link_pkg::ST_STANDBY;
               end
            end
            link_pkg::ST_TRANSMIT: begin
               if (!tx_s) begin
                  state_reg <= READY_REQ ? link_pkg::ST_READY : link_pkg::ST_STANDBY;
               end
            end
            link_pkg::ST_RECEIVE: begin
               if (!rx_s) begin
                  state_reg <= READY_REQ ? link_pkg::ST_READY : link_pkg::ST_STANDBY;
               end
            end
            link_pkg::ST_SLEEP: begin
               state_reg <= link_pkg::ST_SLEEP;
            end
            default: begin
               state_reg <= link_pkg::ST_RESET;
            end
         endcase
      end
   end

   // Completion pending after reset or sleep exit, shown on the next rise
   always_ff @(posedge MCLK or negedge arst_n) begin
      if (!arst_n) begin
         wake_reg <= 1'h0;
      end else if ((state_reg == link_pkg::ST_SLEEP) && tx_s && rx_s) begin
         wake_reg <= 1'h1;
      end else if (rise && (state_reg == link_pkg::ST_RESET)) begin
         wake_reg <= 1'h1;
      end else if (rise && (state_reg == link_pkg::ST_STANDBY)) begin
         wake_reg <= 1'h0;
      end
   end

   // Tail count after the end of reception
   always_ff @(posedge MCLK or negedge arst_n) begin
      if (!arst_n) begin
         tail_reg <= '0;
      end else if (rise) begin
         if (!in_rx) begin
            tail_reg <= '0;
         end else if (RX_AIR_DONE && flag_reg && (tail_reg == '0)) begin
            tail_reg <= TAIL_LD;
         end else if (tail_reg != '0) begin
            tail_reg <= tail_reg - TW'(1);
         end
      end
   end

   always_ff @(posedge MCLK or negedge arst_n) begin
      if (!arst_n) begin
         flag_reg <= link_pkg::FLAG_RST;
      end else if (rise) begin
         if (in_tx) begin
            if (TX_AIR_START) begin
               flag_reg <= 1'h1;
            end else if (TX_AIR_DONE) begin
               flag_reg <= 1'h0;
            end
         end else if (in_rx) begin
            if (tail_reg == TAIL_ONE) begin
               flag_reg <= 1'h0;
            end else if (RX_PREAMBLE && (tail_reg == '0)) begin
               flag_reg <= 1'h1;
            end
         end else if (state_reg == link_pkg::ST_STANDBY) begin
            flag_reg <= wake_reg;
         end else begin
            flag_reg <= 1'h0;
         end
      end
   end

   // Strobe and bus drive, all launched on the interface clock rise
   always_ff @(posedge MCLK or negedge arst_n) begin
      if (!arst_n) begin
         strobe_reg <= 1'h0;
         dout_reg   <= link_pkg::BUS_IDLE;
         doe_reg    <= 1'h0;
      end else if (rise) begin
         strobe_reg <= (in_tx && TX_NEED) || (in_rx && RX_BYTE_VALID);
         dout_reg   <= in_rx ? RX_BYTE : MGMT_DATA;
         doe_reg    <= in_rx || (!in_tx && MGMT_PHY_DRIVES);
      end
   end

   always_ff @(posedge MCLK or negedge arst_n) begin
      if (!arst_n) begin
         cca_reg <= 1'h0;
      end else if (rise) begin
         cca_reg <= CCA_CLEAR;
      end
   end

   // Bytes from the controller, taken at a rise while qualified
   always_ff @(posedge MCLK or negedge arst_n) begin
      if (!arst_n) begin
         txb_reg <= link_pkg::BUS_IDLE;
         txv_reg <= 1'h0;
      end else begin
         txv_reg <= rise && in_tx && qual_s;
         if (rise && in_tx && qual_s) begin
            txb_reg <= dat_s;
         end
      end
   end

   assign LINK.phy_interface_clock  = pclk_reg;
   assign LINK.air_activity_flag    = flag_reg;
   assign LINK.phy_data_strobe      = strobe_reg;
   assign LINK.phy_data_out         = dout_reg;
   assign LINK.phy_data_oe          = doe_reg;
   assign LINK.channel_clear_result = cca_reg;
   assign TX_BYTE                   = txb_reg;
   assign TX_BYTE_VALID             = txv_reg;
   assign LINK_TICK                 = tick_reg;
   assign POWER_STATE               = state_reg;

endmodule

// file: mac_link_end.sv
// Controller side of the link: mode requests, returned clock, byte handshake.
// Assumes the interface clock from the phy end may stop; user side runs on MCLK.
module mac_link_end (
   input  wire logic                        MCLK,
   input  wire logic                        RESETN,
   link_if.mac                              LINK,
   input  wire logic                        INTERFACE_RESET_N_REQ,
   input  wire logic                        TX_MODE,
   input  wire logic                        RX_MODE,
   input  wire logic                        CLK_STOP,
   input  wire logic                        MGMT_MAC_DRIVES,
   input  wire logic [link_pkg::DATA_W-1:0] MGMT_DATA,
   input  wire logic [link_pkg::DATA_W-1:0] TX_DATA,
   input  wire logic                        TX_LOAD,
   output logic                             TX_READY,
   output logic [link_pkg::DATA_W-1:0]      RX_DATA,
   output logic                             RX_VALID,
   output logic                             AIR_ACTIVE,
   output logic                             CHANNEL_CLEAR
);

   logic                        rstn_reg;
   logic                        txm_reg;
   logic                        rxm_reg;
   logic                        stop_reg;
   logic [link_pkg::DATA_W-1:0] hold_reg;
   logic                        req_tgl_reg;
   logic                        ready_reg;
   logic [3:0]                  m1_reg;
   logic [3:0]                  m2_reg;
   logic                        m3_reg;
   logic [link_pkg::DATA_W-1:0] rxd_reg;
   logic                        rxv_reg;
   logic                        act_reg;
   logic                        cca_reg;
   logic [3:0]                  p1_reg;
   logic [3:0]                  p2_reg;
   logic                        ack_tgl_reg;
   logic                        qual_reg;
   logic [link_pkg::DATA_W-1:0] dout_reg;
   logic                        doe_reg;
   logic [link_pkg::DATA_W-1:0] rx_hold_reg;
   logic                        rx_tgl_reg;
   logic                        pclk;
   logic                        strb_reg;
   logic [link_pkg::DATA_W-1:0] bus_reg;
   logic                        p_tx;
   logic                        p_rx;
   logic                        p_mgmt;
   logic                        p_req;

   // Mode and stop requests come from MCLK so they toggle with the link clock stopped
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rstn_reg <= 1'h0;
         txm_reg  <= 1'h0;
         rxm_reg  <= 1'h0;
         stop_reg <= 1'h0;
      end else begin
         rstn_reg <= !INTERFACE_RESET_N_REQ;
         txm_reg  <= TX_MODE;
         rxm_reg  <= RX_MODE;
         stop_reg <= CLK_STOP;
      end
   end

   // Word handshake towards the link domain
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         hold_reg    <= link_pkg::BUS_IDLE;
         req_tgl_reg <= 1'h0;
         ready_reg   <= 1'h1;
      end else if (TX_LOAD && ready_reg) begin
         hold_reg    <= TX_DATA;
         req_tgl_reg <= ~req_tgl_reg;
         ready_reg   <= 1'h0;
      end else if (m2_reg[0] == req_tgl_reg) begin
         ready_reg   <= 1'h1;
      end
   end

   // Synchronisers into MCLK: ack toggle, receive toggle, flag, channel result
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         m1_reg  <= '0;
         m2_reg  <= '0;
         m3_reg  <= 1'h0;
         rxd_reg <= link_pkg::BUS_IDLE;
         rxv_reg <= 1'h0;
         act_reg <= 1'h0;
         cca_reg <= 1'h0;
      end else begin
         m1_reg  <= {LINK.air_activity_flag, LINK.channel_clear_result, rx_tgl_reg, ack_tgl_reg};
         m2_reg  <= m1_reg;
         m3_reg  <= m2_reg[1];
         rxv_reg <= m2_reg[1] ^ m3_reg;
         if (m2_reg[1] ^ m3_reg) begin
            rxd_reg <= rx_hold_reg;
         end
         act_reg <= m2_reg[3];
         cca_reg <= m2_reg[2];
      end
   end

   // Link domain runs on the interface clock; it may stop outside frames
   assign pclk = LINK.phy_interface_clock;

   always_ff @(posedge pclk or negedge RESETN) begin
      if (!RESETN) begin
         p1_reg <= '0;
         p2_reg <= '0;
      end else begin
         p1_reg <= {txm_reg, rxm_reg, MGMT_MAC_DRIVES, req_tgl_reg};
         p2_reg <= p1_reg;
      end
   end

   // Half-period capture: device outputs launch on the same rise that clocks this end
   always_ff @(negedge pclk or negedge RESETN) begin
      if (!RESETN) begin
         strb_reg <= 1'h0;
         bus_reg  <= link_pkg::BUS_IDLE;
      end else begin
         strb_reg <= LINK.phy_data_strobe;
         bus_reg  <= LINK.data_bus;
      end
   end

   assign p_tx   = p2_reg[3];
   assign p_rx   = p2_reg[2];
   assign p_mgmt = p2_reg[1];
   assign p_req  = p2_reg[0];

   // One qualified byte per strobe cycle while a word is pending
   always_ff @(posedge pclk or negedge RESETN) begin
      if (!RESETN) begin
         ack_tgl_reg <= 1'h0;
         qual_reg    <= 1'h0;
         dout_reg    <= link_pkg::BUS_IDLE;
      end else if (p_tx && strb_reg && (p_req != ack_tgl_reg) && !qual_reg) begin
         ack_tgl_reg <= ~ack_tgl_reg;
         qual_reg    <= 1'h1;
         dout_reg    <= hold_reg;
      end else begin
         qual_reg    <= 1'h0;
         if (!p_tx) begin
            dout_reg <= MGMT_DATA;
         end
      end
   end

   always_ff @(posedge pclk or negedge RESETN) begin
      if (!RESETN) begin
         doe_reg <= 1'h0;
      end else begin
         doe_reg <= p_tx || (!p_rx && p_mgmt);
      end
   end

   // Received bytes; hold stays stable until the toggle has crossed
   always_ff @(posedge pclk or negedge RESETN) begin
      if (!RESETN) begin
         rx_hold_reg <= link_pkg::BUS_IDLE;
         rx_tgl_reg  <= 1'h0;
      end else if (p_rx && !p_tx && strb_reg) begin
         rx_hold_reg <= bus_reg;
         rx_tgl_reg  <= ~rx_tgl_reg;
      end
   end

   // Returned clock is the received one; board delay makes it the delayed copy
   assign LINK.mac_interface_clock = pclk;
   assign LINK.interface_reset_n   = rstn_reg;
   assign LINK.transmit_request    = txm_reg;
   assign LINK.receive_request     = rxm_reg;
   assign LINK.pclk_stop_request   = stop_reg;
   assign LINK.mac_data_qualifier  = qual_reg;
   assign LINK.mac_data_out        = dout_reg;
   assign LINK.mac_data_oe         = doe_reg;
   assign TX_READY                 = ready_reg;
   assign RX_DATA                  = rxd_reg;
   assign RX_VALID                 = rxv_reg;
   assign AIR_ACTIVE               = act_reg;
   assign CHANNEL_CLEAR            = cca_reg;

endmodule

// file: link_props.sv
// Link checker: handshake, bus ownership and flag timing on the joined wires.
// Assumes instantiation beside the interface; judged on interface clock rises.
module link_props (
   input wire logic phy_interface_clock,
   input wire logic interface_reset_n,
   input wire logic transmit_request,
   input wire logic receive_request,
   input wire logic air_activity_flag,
   input wire logic phy_data_strobe,
   input wire logic mac_data_qualifier,
   input wire logic phy_data_oe,
   input wire logic mac_data_oe
);
   default clocking @(posedge phy_interface_clock); endclocking
   default disable iff (!interface_reset_n);
   AST_BUS_ONE: assert property (!(phy_data_oe && mac_data_oe))
      else $error("bus driven by both ends");
   AST_QUAL_ONE: assert property (mac_data_qualifier |=> !mac_data_qualifier)
      else $error("qualifier longer than one period");
   AST_QUAL_ASKED: assert property ($rose(mac_data_qualifier) |-> $past(phy_data_strobe))
      else $error("qualifier without strobe");
   AST_QUAL_DRIVES: assert property (mac_data_qualifier |-> mac_data_oe && !phy_data_oe)
      else $error("qualified byte not driven by controller");
   AST_IDLE_STROBE: assert property ((!transmit_request && !receive_request)[*4]
      |-> !phy_data_strobe) else $error("strobe outside transfer modes");
   AST_FLAG_PULSE: assert property ($rose(air_activity_flag)
      && transmit_request == receive_request |=> !air_activity_flag)
      else $error("exit pulse too long");
   AST_RX_NO_MAC: assert property (receive_request[*4] |-> !mac_data_oe)
      else $error("controller drives bus in receive");
   AST_TX_NO_PHY: assert property (transmit_request[*4] |-> !phy_data_oe)
      else $error("device drives bus in transmit");
   AST_RX_STROBE: assert property (receive_request && phy_data_strobe |-> phy_data_oe)
      else $error("receive strobe without byte");
endmodule

// file: radio_phy_data_control_link_tb.sv
// Bench: both link ends joined; user sides driven on falling MCLK, except reset and the receive-mode release after the tail count.
// Assumes interface clock made by the device end's divider.
module radio_phy_data_control_link_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TL = 4;
   logic mclk = 0, resetn = 1, tx_mode = 0, rx_mode = 0, clk_stop = 0, slp = 0;
   logic tx_need = 0, cca = 0, mg_p = 0, mg_m = 0, tx_load = 0, rdq = 0;
   logic [4:0] evb = 5'h00;
   logic [7:0] rxb = 8'h00, md = 8'h00, txd = 8'h00;
   wire logic [7:0] tx_byte, rx_data;
   wire logic tx_bv, tick, rx_v, clr, rdy, act;
   wire logic [2:0] pst;
   int bad_count = 0, n_checks = 0, pe = 0, fr = 0, n;
   link_if link ();
   always #10 mclk = ~mclk;
   always @(posedge link.phy_interface_clock) pe++;
   always @(posedge link.air_activity_flag) fr++;
   phy_link_end #(.HALF(2), .TAIL(TL)) u_phy_link_end (.MCLK(mclk), .RESETN(resetn),
      .LINK(link.phy), .SLEEP_REQ(slp), .READY_REQ(rdq), .TX_AIR_START(evb[0]),
      .TX_AIR_DONE(evb[1]), .TX_NEED(tx_need), .RX_PREAMBLE(evb[2]), .RX_BYTE(rxb),
      .RX_BYTE_VALID(evb[3]), .RX_AIR_DONE(evb[4]), .CCA_CLEAR(cca),
      .MGMT_PHY_DRIVES(mg_p), .MGMT_DATA(md), .TX_BYTE(tx_byte), .TX_BYTE_VALID(tx_bv),
      .LINK_TICK(tick), .POWER_STATE(pst));
   mac_link_end u_mac_link_end (.MCLK(mclk), .RESETN(resetn), .LINK(link.mac),
      .INTERFACE_RESET_N_REQ(1'b0), .TX_MODE(tx_mode), .RX_MODE(rx_mode), .CLK_STOP(clk_stop),
      .MGMT_MAC_DRIVES(mg_m), .MGMT_DATA(md), .TX_DATA(txd), .TX_LOAD(tx_load),
      .TX_READY(rdy), .RX_DATA(rx_data), .RX_VALID(rx_v), .AIR_ACTIVE(act),
      .CHANNEL_CLEAR(clr));
   link_props props (.phy_interface_clock(link.phy_interface_clock),
      .interface_reset_n(link.interface_reset_n), .transmit_request(link.transmit_request),
      .receive_request(link.receive_request), .air_activity_flag(link.air_activity_flag),
      .phy_data_strobe(link.phy_data_strobe), .mac_data_qualifier(link.mac_data_qualifier),
      .phy_data_oe(link.phy_data_oe), .mac_data_oe(link.mac_data_oe));
   task chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   task stop_test;
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task wst(input logic [2:0] s);
      while (pst !== s) @(negedge mclk);
   endtask
   // Events count once only when held across exactly one tick edge
   task ev(input int k);
      @(negedge mclk);
      while (tick !== 1'b1) @(negedge mclk);
      evb[k] = 1'b1;
      cyc(1);
      evb[k] = 1'b0;
   endtask
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
   initial begin
      // Falling reset edge after time zero so every async reset really fires
      #1 resetn = 1'h0;
      cyc(10);
      resetn = 1'b1;
      wst(3'h2);
      cyc(8);
      chk("reset_pulse", 8'h01, 8'(fr));
      md = 8'h5A;
      mg_p = 1'b1;
      cyc(12);
      chk("bus_dev", 8'h5A, link.data_bus);
      mg_p = 1'b0;
      cyc(12);
      md = 8'hC3;
      mg_m = 1'b1;
      cyc(12);
      chk("bus_ctl", 8'hC3, link.data_bus);
      mg_m = 1'b0;
      rdq = 1'b1;
      wst(3'h3);
      n = pe;
      cyc(20);
      chk("clk_ready", 8'h01, {7'h00, pe > n});
      rdq = 1'b0;
      wst(3'h2);
      for (int v = 1; v >= 0; v--) begin
         cca = v[0];
         cyc(16);
         chk("cca", 8'(v), {7'h00, link.channel_clear_result});
         chk("cca_user", 8'(v), {7'h00, clr});
      end
      tx_mode = 1'b1;
      wst(3'h4);
      tx_need = 1'b1;
      txd = 8'hA5;
      tx_load = 1'b1;
      cyc(1);
      tx_load = 1'b0;
      wait (tx_bv === 1'b1);
      cyc(1);
      tx_need = 1'b0;
      chk("tx_byte", 8'hA5, tx_byte);
      cyc(8);
      chk("tx_ready", 8'h01, {7'h00, rdy});
      ev(0);
      chk("flag_tx_on", 8'h01, {7'h00, link.air_activity_flag});
      ev(1);
      chk("flag_tx_off", 8'h00, {7'h00, link.air_activity_flag});
      tx_mode = 1'b0;
      wst(3'h2);
      rx_mode = 1'b1;
      wst(3'h5);
      ev(2);
      chk("flag_rx_on", 8'h01, {7'h00, link.air_activity_flag});
      cyc(4);
      chk("air_user", 8'h01, {7'h00, act});
      rxb = 8'h3C;
      ev(3);
      wait (rx_v === 1'b1);
      chk("rx_data", 8'h3C, rx_data);
      ev(4);
      n = 0;
      while (link.air_activity_flag === 1'b1 && n < 40) begin
         @(posedge link.phy_interface_clock);
         #1;
         n++;
      end
      chk("tail", 8'(TL), 8'(n));
      rx_mode = 1'b0;
      wst(3'h2);
      clk_stop = 1'b1;
      cyc(20);
      n = pe;
      cyc(40);
      chk("clk_stopped", 8'h00, 8'(pe - n));
      clk_stop = 1'b0;
      cyc(20);
      chk("clk_restart", 8'h01, {7'h00, pe > n});
      slp = 1'b1;
      wst(3'h1);
      slp = 1'b0;
      n = pe;
      cyc(40);
      chk("clk_sleep", 8'h00, 8'(pe - n));
      n = fr;
      tx_mode = 1'b1;
      rx_mode = 1'b1;
      wst(3'h2);
      cyc(8);
      chk("wake_pulse", 8'h01, 8'(fr - n));
      tx_mode = 1'b0;
      rx_mode = 1'b0;
      cyc(8);
      stop_test();
   end
endmodule
